//--- agc_gain_regs.sv
// audio gain and automatic gain control register bank
`timescale 1ns/1ps
`default_nettype none
`include "agc_regs.svh"

module agc_gain_regs
	import agc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output var  logic [15:0] reg_rdata,
	input  wire logic        aux_input_selected,
	input  wire logic        level_above_target,
	output var  logic        aux_pga_mute,
	output var  logic [6:0]  aux_pga_gain,
	output var  logic [2:0]  agc_target_out,
	output var  logic        left_dac_mute_out,
	output var  logic [6:0]  left_dac_atten,
	output var  logic        right_dac_mute_out,
	output var  logic [6:0]  right_dac_atten
);

	////////////////////////////////////////////////////////////////////////
	logic        aux_input_mute_q;
	agc_gain_t   aux_input_pga_gain_q;
	agc_target_t auto_gain_target_level_q;
	agc_tc_t     auto_gain_time_constants_q;
	logic        auto_gain_enable_q;
	logic        left_dac_mute_q;
	agc_gain_t   left_dac_volume_q;
	logic        right_dac_mute_q;
	agc_gain_t   right_dac_volume_q;
	agc_gain_t   agc_gain_q;
	logic [24:0] tick_cnt_q;
	logic        agc_active;
	logic        wr_in;
	logic        wr_dac;
	logic [24:0] step_period;

	// register index match, shared by the write decode and the read mux
	function automatic logic addr_hit(input logic [6:0] addr,
		input logic [6:0] ofs);
		addr_hit = (addr == ofs);
	endfunction : addr_hit

	assign agc_active = auto_gain_enable_q && aux_input_selected;
	assign wr_in      = reg_wr && addr_hit(reg_addr, `AGC_OFS_INPUT_GAIN);
	assign wr_dac     = reg_wr && addr_hit(reg_addr, `AGC_OFS_DAC_GAIN);

	// attack period from low pair, decay from high pair, in clock cycles
	function automatic logic [24:0] agc_period(input agc_tc_t tc,
		input logic attack);
		logic [9:0] ms;
		ms = 10'h000;
		if (attack)
			unique case (tc[1:0])
				2'h0: ms = `AGC_ATTACK_MS_0;
				2'h1: ms = `AGC_ATTACK_MS_1;
				2'h2: ms = `AGC_ATTACK_MS_2;
				2'h3: ms = `AGC_ATTACK_MS_3;
			endcase
		else
			unique case (tc[3:2])
				2'h0: ms = `AGC_DECAY_MS_0;
				2'h1: ms = `AGC_DECAY_MS_1;
				2'h2: ms = `AGC_DECAY_MS_2;
				2'h3: ms = `AGC_DECAY_MS_3;
			endcase
		// whole ramp over the full code range, so one step is span/0x77
		agc_period = 25'((32'(ms) * `AGC_MS_CYCLES) / 32'(`AGC_GAIN_MAX));
	endfunction : agc_period

	// cycle counts come from mclk alone, so sample rate does not matter
	assign step_period = agc_period(auto_gain_time_constants_q,
		level_above_target);

	////////////////////////////////////////////////////////////////////////
	// input gain register
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			aux_input_mute_q           <= `AGC_RST_IN_MUTE;
			aux_input_pga_gain_q       <= `AGC_RST_IN_GAIN;
			auto_gain_target_level_q   <= `AGC_RST_IN_TARGET;
			auto_gain_time_constants_q <= `AGC_RST_IN_TC;
			auto_gain_enable_q         <= `AGC_RST_IN_ENABLE;
		end
		else if (wr_in)
		begin
			aux_input_mute_q           <= reg_wdata[`AGC_IN_MUTE_BIT];
			aux_input_pga_gain_q       <=
				reg_wdata[`AGC_IN_GAIN_MSB:`AGC_IN_GAIN_LSB];
			auto_gain_target_level_q   <=
				reg_wdata[`AGC_IN_TARGET_MSB:`AGC_IN_TARGET_LSB];
			auto_gain_time_constants_q <=
				reg_wdata[`AGC_IN_TC_MSB:`AGC_IN_TC_LSB];
			auto_gain_enable_q         <= reg_wdata[`AGC_IN_ENABLE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dac gain register
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			left_dac_mute_q    <= `AGC_RST_DAC_MUTE;
			left_dac_volume_q  <= `AGC_RST_DAC_VOL;
			right_dac_mute_q   <= `AGC_RST_DAC_MUTE;
			right_dac_volume_q <= `AGC_RST_DAC_VOL;
		end
		else if (wr_dac)
		begin
			left_dac_mute_q    <= reg_wdata[`AGC_DAC_LMUTE_BIT];
			left_dac_volume_q  <= reg_wdata[`AGC_DAC_LVOL_MSB:`AGC_DAC_LVOL_LSB];
			right_dac_mute_q   <= reg_wdata[`AGC_DAC_RMUTE_BIT];
			right_dac_volume_q <= reg_wdata[`AGC_DAC_RVOL_MSB:`AGC_DAC_RVOL_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gain stepping: lower while level is above target, else raise
	always_ff @(posedge mclk)
	begin
		if (!nrst || !agc_active)
		begin
			tick_cnt_q <= 25'h0000000;
			agc_gain_q <= 7'h00;
		end
		else if (tick_cnt_q + 25'h0000001 >= step_period)
		begin
			tick_cnt_q <= 25'h0000000;
			if (level_above_target && agc_gain_q != 7'h00)
				agc_gain_q <= agc_gain_q - 7'h01;
			else if (!level_above_target && agc_gain_q < `AGC_GAIN_MAX)
				agc_gain_q <= agc_gain_q + 7'h01;
		end
		else
			tick_cnt_q <= tick_cnt_q + 25'h0000001;
	end

	////////////////////////////////////////////////////////////////////////
	// analog drive; the agc never mutes
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			aux_pga_mute       <= `AGC_RST_IN_MUTE;
			aux_pga_gain       <= `AGC_RST_IN_GAIN;
			agc_target_out     <= `AGC_RST_IN_TARGET;
			left_dac_mute_out  <= `AGC_RST_DAC_MUTE;
			left_dac_atten     <= `AGC_RST_DAC_VOL;
			right_dac_mute_out <= `AGC_RST_DAC_MUTE;
			right_dac_atten    <= `AGC_RST_DAC_VOL;
		end
		else
		begin
			aux_pga_mute       <= agc_active ? 1'b0 : aux_input_mute_q;
			aux_pga_gain       <= agc_active ? agc_gain_q
				: aux_input_pga_gain_q;
			agc_target_out     <= auto_gain_target_level_q;
			left_dac_mute_out  <= left_dac_mute_q;
			left_dac_atten     <= left_dac_volume_q;
			right_dac_mute_out <= right_dac_mute_q;
			right_dac_atten    <= right_dac_volume_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data registered one cycle after the strobe; unmapped reads zero
	always_ff @(posedge mclk)
	begin
		if (!nrst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			if (addr_hit(reg_addr, `AGC_OFS_INPUT_GAIN))
				reg_rdata <= {agc_active ? 1'b0 : aux_input_mute_q,
					agc_active ? agc_gain_q : aux_input_pga_gain_q,
					auto_gain_target_level_q, auto_gain_time_constants_q,
					auto_gain_enable_q};
			else if (addr_hit(reg_addr, `AGC_OFS_DAC_GAIN))
				reg_rdata <= {left_dac_mute_q, left_dac_volume_q,
					right_dac_mute_q, right_dac_volume_q};
			else
				reg_rdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_in_reset;
		@(posedge mclk) !nrst |=> reg_rdata == 16'h0000 && aux_pga_mute;
	endproperty
	a_in_reset: assert property (p_in_reset) else $error("reset values");
	property p_manual;
		@(posedge mclk) disable iff (!nrst)
		!agc_active |=> aux_pga_gain == $past(aux_input_pga_gain_q);
	endproperty
	a_manual: assert property (p_manual) else $error("manual gain");
	property p_agc_drive;
		@(posedge mclk) disable iff (!nrst)
		agc_active |=> !aux_pga_mute && aux_pga_gain == $past(agc_gain_q);
	endproperty
	a_agc_drive: assert property (p_agc_drive) else $error("agc drive");
	property p_ceiling;
		@(posedge mclk) disable iff (!nrst) agc_gain_q <= `AGC_GAIN_MAX;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("agc over max");
	property p_readback;
		@(posedge mclk) disable iff (!nrst)
		reg_rd && agc_active && reg_addr == `AGC_OFS_INPUT_GAIN
		|=> reg_rdata[14:8] == $past(agc_gain_q) && !reg_rdata[15];
	endproperty
	a_readback: assert property (p_readback) else $error("readback");
	property p_left;
		@(posedge mclk) disable iff (!nrst)
		wr_dac ##2 !$past(wr_dac) |-> left_dac_atten == $past(reg_wdata[14:8], 2);
	endproperty
	a_left: assert property (p_left) else $error("left volume");
	property p_right;
		@(posedge mclk) disable iff (!nrst)
		wr_dac ##2 !$past(wr_dac) |-> right_dac_mute_out == $past(reg_wdata[7], 2)
			&& right_dac_atten == $past(reg_wdata[6:0], 2);
	endproperty
	a_right: assert property (p_right) else $error("right channel");
	property p_hold;
		@(posedge mclk) disable iff (!nrst)
		!wr_in |=> $stable(auto_gain_target_level_q)
			&& $stable(auto_gain_time_constants_q);
	endproperty
	a_hold: assert property (p_hold) else $error("field changed");
	property p_step;
		@(posedge mclk) disable iff (!nrst)
		agc_active && tick_cnt_q + 25'h0000001 < step_period
		|=> $stable(agc_gain_q) || !agc_active;
	endproperty
	a_step: assert property (p_step) else $error("step too early");

	////////////////////////////////////////////////////////////////////////
	// write checks compare against bus data two edges back, so a miswired field shows
	property p_in_mute;
		@(posedge mclk) disable iff (!nrst)
		!agc_active |=> aux_pga_mute == $past(aux_input_mute_q);
	endproperty
	a_in_mute: assert property (p_in_mute) else $error("input mute");
	property p_in_write;
		@(posedge mclk) disable iff (!nrst)
		wr_in ##1 (!wr_in && !agc_active) |=>
			aux_pga_mute == $past(reg_wdata[`AGC_IN_MUTE_BIT], 2)
			&& aux_pga_gain ==
			$past(reg_wdata[`AGC_IN_GAIN_MSB:`AGC_IN_GAIN_LSB], 2);
	endproperty
	a_in_write: assert property (p_in_write) else $error("pga gain");
	property p_target;
		@(posedge mclk) disable iff (!nrst)
		wr_in ##2 !$past(wr_in) |-> agc_target_out ==
			$past(reg_wdata[`AGC_IN_TARGET_MSB:`AGC_IN_TARGET_LSB], 2);
	endproperty
	a_target: assert property (p_target) else $error("target level");
	property p_left_mute;
		@(posedge mclk) disable iff (!nrst)
		wr_dac ##2 !$past(wr_dac) |-> left_dac_mute_out ==
			$past(reg_wdata[`AGC_DAC_LMUTE_BIT], 2);
	endproperty
	a_left_mute: assert property (p_left_mute) else $error("left mute");
	property p_unmapped;
		@(posedge mclk) disable iff (!nrst)
		reg_rd && reg_addr != `AGC_OFS_INPUT_GAIN
			&& reg_addr != `AGC_OFS_DAC_GAIN |=> reg_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_rd_hold;
		@(posedge mclk) disable iff (!nrst) !reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_fall;
		@(posedge mclk) disable iff (!nrst)
		agc_active && level_above_target |=> agc_gain_q <= $past(agc_gain_q);
	endproperty
	a_fall: assert property (p_fall) else $error("agc rose on attack");
	property p_rise;
		@(posedge mclk) disable iff (!nrst)
		agc_active && !level_above_target |=> agc_gain_q >= $past(agc_gain_q);
	endproperty
	a_rise: assert property (p_rise) else $error("agc fell on decay");
	// one 0.5 dB code per step, never a jump
	property p_one_step;
		@(posedge mclk) disable iff (!nrst)
		agc_active |=> agc_gain_q == $past(agc_gain_q)
			|| agc_gain_q == $past(agc_gain_q) + 7'h01
			|| agc_gain_q == $past(agc_gain_q) - 7'h01;
	endproperty
	a_one_step: assert property (p_one_step) else $error("agc jump");

endmodule : agc_gain_regs
`default_nettype wire

//--- agc_pkg.sv
// types shared by the gain control register bank
`default_nettype none
package agc_pkg;
	typedef logic [6:0] agc_gain_t;
	typedef logic [2:0] agc_target_t;
	typedef logic [3:0] agc_tc_t;
endpackage : agc_pkg
`default_nettype wire

//--- agc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef AGC_REGS_SVH
`define AGC_REGS_SVH

`define AGC_OFS_INPUT_GAIN      7'h01
`define AGC_OFS_DAC_GAIN        7'h02

`define AGC_IN_MUTE_BIT         15
`define AGC_IN_GAIN_MSB         14
`define AGC_IN_GAIN_LSB         8
`define AGC_IN_TARGET_MSB       7
`define AGC_IN_TARGET_LSB       5
`define AGC_IN_TC_MSB           4
`define AGC_IN_TC_LSB           1
`define AGC_IN_ENABLE_BIT       0

`define AGC_DAC_LMUTE_BIT       15
`define AGC_DAC_LVOL_MSB        14
`define AGC_DAC_LVOL_LSB        8
`define AGC_DAC_RMUTE_BIT       7
`define AGC_DAC_RVOL_MSB        6
`define AGC_DAC_RVOL_LSB        0

`define AGC_RST_INPUT_GAIN      16'hFF00
`define AGC_RST_DAC_GAIN        16'hFFFF

// per-field reset values
`define AGC_RST_IN_MUTE         1'b1
`define AGC_RST_IN_GAIN         7'h7F
`define AGC_RST_IN_TARGET       3'h0
`define AGC_RST_IN_TC           4'h0
`define AGC_RST_IN_ENABLE       1'b0
`define AGC_RST_DAC_MUTE        1'b1
`define AGC_RST_DAC_VOL         7'h7F

// agc gain ceiling: code 0x77 reads back as +59.5 dB
`define AGC_GAIN_MAX            7'h77

// one millisecond at 50 MHz
`define AGC_CLK_MHZ             50
`define AGC_MS_CYCLES           (`AGC_CLK_MHZ * 1000)

// attack times in ms, selected by the low pair of the time constant field
`define AGC_ATTACK_MS_0         10'h008
`define AGC_ATTACK_MS_1         10'h00B
`define AGC_ATTACK_MS_2         10'h010
`define AGC_ATTACK_MS_3         10'h014

// decay times in ms, selected by the high pair of the time constant field
`define AGC_DECAY_MS_0          10'h064
`define AGC_DECAY_MS_1          10'h0C8
`define AGC_DECAY_MS_2          10'h190
`define AGC_DECAY_MS_3          10'h1F4

`endif

//--- test_audio_gain_agc_control.sv
// self-checking testbench for the gain and agc register bank
`timescale 1ns/1ps
`default_nettype none
module test_audio_gain_agc_control
	import agc_pkg::*;
;
	logic        mclk;
	logic        nrst;
	logic        reg_wr;
	logic        reg_rd;
	logic        sel;
	logic        above;
	logic [6:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        a_mute;
	agc_gain_t   a_gain;
	agc_target_t tgt;
	logic        l_mute;
	logic        r_mute;
	logic [6:0]  l_att;
	logic [6:0]  r_att;
	logic [15:0] rv;
	int          n_fail;
	int          n_compared;
	agc_gain_regs u_dut (.mclk(mclk), .nrst(nrst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .aux_input_selected(sel),
		.level_above_target(above), .aux_pga_mute(a_mute),
		.aux_pga_gain(a_gain), .agc_target_out(tgt),
		.left_dac_mute_out(l_mute), .left_dac_atten(l_att),
		.right_dac_mute_out(r_mute), .right_dac_atten(r_att));
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : ck
	// outputs land one edge after the write edge; the task waits two
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	function automatic logic [15:0] dac_outs();
		return {l_mute, l_att, r_mute, r_att};
	endfunction : dac_outs
	task automatic print_verdict();
		$display("compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		@(posedge mclk);
		#1;
		ck({a_mute, a_gain, 5'h00, tgt}, 16'hFF00);
		ck(dac_outs(), 16'hFFFF);
		rd(7'h01, rv);
		ck(rv, 16'hFF00);
		rd(7'h02, rv);
		ck(rv, 16'hFFFF);
		$display("test reset done");
	endtask : t_reset
	task automatic t_dac();
		wr(7'h02, 16'h0A55);
		ck(dac_outs(), 16'h0A55);
		wr(7'h02, 16'h8000);
		ck(dac_outs(), 16'h8000);
		wr(7'h03, 16'h1234);
		rd(7'h03, rv);
		ck(rv, 16'h0000);
		rd(7'h02, rv);
		ck(rv, 16'h8000);
		$display("test dac done");
	endtask : t_dac
	task automatic t_fields();
		logic [15:0] d;
		for (int i = 0; i < 16; i++)
		begin
			d = {i[0], 4'(i), i[2:0], i[2:0], 4'(i), 1'b0};
			wr(7'h01, d);
			ck({a_mute, a_gain, 5'h00, tgt}, {d[15:8], 5'h00, d[7:5]});
			rd(7'h01, rv);
			ck(rv, d);
		end
		$display("test fields done");
	endtask : t_fields
	// decay code 00 steps one code per 42016 cycles
	task automatic t_agc();
		@(posedge mclk);
		sel   <= 1'b1;
		above <= 1'b1;
		wr(7'h01, 16'hFFE1);
		rd(7'h01, rv);
		ck(rv, 16'h00E1);
		ck({8'h00, a_mute, a_gain}, 16'h0000);
		@(posedge mclk);
		above <= 1'b0;
		repeat (45000) @(posedge mclk);
		#1;
		ck({8'h00, a_mute, a_gain}, 16'h0001);
		rd(7'h01, rv);
		ck(rv, 16'h01E1);
		@(posedge mclk);
		sel <= 1'b0;
		rd(7'h01, rv);
		ck(rv, 16'hFFE1);
		@(posedge mclk);
		sel <= 1'b1;
		wr(7'h01, 16'hFFE0);
		ck({8'h00, a_mute, a_gain}, 16'h00FF);
		rd(7'h01, rv);
		ck(rv, 16'hFFE0);
		$display("test agc done");
	endtask : t_agc
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		n_fail     = 0;
		n_compared = 0;
		nrst       = 1'b0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		sel        = 1'b0;
		above      = 1'b0;
		reg_addr   = 7'h00;
		reg_wdata  = 16'h0000;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_dac();
		t_fields();
		t_agc();
		print_verdict();
	end
endmodule : test_audio_gain_agc_control
`default_nettype wire
